// File: pkg/eiem_map.vh
/*
 * Register map, field positions and reset values of the Ethernet interrupt
 * enable mask block.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef EIEM_MAP_VH
`define EIEM_MAP_VH

// Register byte offsets on the plain register port.
`define EIEM_ADDR_W              8
`define EIEM_OFS_ENABLE          8'h00
`define EIEM_OFS_STATUS          8'h04
`define EIEM_OFS_RAW             8'h08
`define EIEM_OFS_PENDING         8'h0C

// Data width of every register.
`define EIEM_DATA_W              32

// Bit positions of the enable fields, shared with the status layout.
`define EIEM_BIT_RX_DATA_OVR     25
`define EIEM_BIT_RX_STAT_OVR     24
`define EIEM_BIT_RX_BUF_CLOSED   23
`define EIEM_BIT_RX_DONE_A       22
`define EIEM_BIT_RX_DONE_B       21
`define EIEM_BIT_RX_DONE_C       20
`define EIEM_BIT_RX_DONE_D       19
`define EIEM_BIT_RX_NO_BUF       18
`define EIEM_BIT_RX_BUF_FULL     17
`define EIEM_BIT_RX_BCAST_REJ    16
`define EIEM_BIT_STAT_OVR        6
`define EIEM_BIT_SPARE           5
`define EIEM_BIT_TX_BUF_CLOSED   4
`define EIEM_BIT_TX_DESC_NRDY    3
`define EIEM_BIT_TX_DONE         2

// Bits that hold an interrupt source.
`define EIEM_SRC_MASK            32'h03FF005C
// Bits of the enable register that store a value (sources plus the spare bit).
`define EIEM_EN_WR_MASK          32'h03FF007C

// Reset values.
`define EIEM_ENABLE_RST          32'h00000000
`define EIEM_STATUS_RST          32'h00000000
`define EIEM_RDATA_RST           32'h00000000

`endif

// File: core/eiem_core.v
/*
 * Ethernet interrupt enable mask: per-source sticky status flags, the
 * software enable register that gates them, and the system interrupt line.
 * Assumes event inputs are one-cycle pulses from logic on mclk, and a
 * register master that issues one-cycle read or write strobes.
 */
// Implementation choices: the address map and the address-and-strobe port.
// Operation
// - Bit 24 enables the receive status-overflow flag onto the interrupt; resets to zero.
// - Bit 23 enables the receive-buffer-closed flag onto the interrupt; resets to zero.
// - Bit 22 enables the ring A receive-complete flag; read/write, resets to zero.
// - Bit 21 enables the ring B receive-complete flag; read/write, resets to zero.
// - Bit 20 enables the ring C receive-complete flag; read/write, resets to zero.
// - Bit 19 enables the ring D receive-complete flag; read/write, resets to zero.
// - Bit 18 enables the no-receive-buffer flag; read/write, resets to zero.
// - Bit 17 enables the receive-buffer-full flag; read/write, resets to zero.
// - Bit 16 enables the receive broadcast-reject flag; read/write, resets to zero.
// - Bits 15 to 7 are reserved, hold nothing and read as zero.
// - Bit 6 enables the statistics-overflow flag; read/write, resets to zero.
// - Bit 4 enables the transmit-buffer-closed flag; read/write, resets to zero.
// - Bit 3 enables the transmit-descriptor-not-ready flag; read/write, resets to zero.
// - A clear enable bit keeps its set status flag off the interrupt.
// - Bit 25 enables the receive data-overflow flag; read/write, resets to zero.
// - Bit 2 enables the transmit-complete flag; read/write, resets to zero.
`timescale 1ns/10ps
`include "eiem_map.vh"

module eiem_core (
    input  wire                     mclk,
    input  wire                     sys_rst,
    input  wire [`EIEM_ADDR_W-1:0]  reg_addr,
    input  wire [`EIEM_DATA_W-1:0]  reg_wdata,
    input  wire                     reg_wr,
    input  wire                     reg_rd,
    output wire [`EIEM_DATA_W-1:0]  reg_rdata,
    input  wire                     evt_recv_data_overrun,
    input  wire                     evt_recv_status_overrun,
    input  wire                     evt_recv_buffer_closed,
    input  wire                     evt_recv_finished_pool_a,
    input  wire                     evt_recv_finished_pool_b,
    input  wire                     evt_recv_finished_pool_c,
    input  wire                     evt_recv_finished_pool_d,
    input  wire                     evt_recv_no_buffer,
    input  wire                     evt_recv_buffer_full,
    input  wire                     evt_recv_broadcast_reject,
    input  wire                     evt_statistics_overrun,
    input  wire                     evt_xmit_buffer_closed,
    input  wire                     evt_xmit_descriptor_not_ready,
    input  wire                     evt_xmit_finished,
    output wire                     recv_data_overrun_irq_en,
    output wire                     recv_status_overrun_irq_en,
    output wire                     recv_buffer_closed_irq_en,
    output wire                     recv_finished_pool_a_irq_en,
    output wire                     recv_finished_pool_b_irq_en,
    output wire                     recv_finished_pool_c_irq_en,
    output wire                     recv_finished_pool_d_irq_en,
    output wire                     recv_no_buffer_irq_en,
    output wire                     recv_buffer_full_irq_en,
    output wire                     recv_broadcast_reject_irq_en,
    output wire                     statistics_overrun_irq_en,
    output wire                     xmit_buffer_closed_irq_en,
    output wire                     xmit_descriptor_not_ready_irq_en,
    output wire                     xmit_finished_irq_en,
    output wire                     sys_irq
);

    reg  [`EIEM_DATA_W-1:0] enable_ff;
    reg  [`EIEM_DATA_W-1:0] nxt_enable;
    reg  [`EIEM_DATA_W-1:0] status_ff;
    wire [`EIEM_DATA_W-1:0] nxt_status;
    reg  [`EIEM_DATA_W-1:0] rdata_ff;
    reg  [`EIEM_DATA_W-1:0] nxt_rdata;
    reg                     irq_ff;
    wire                    nxt_irq;
    wire [`EIEM_DATA_W-1:0] evt_vec;
    wire [`EIEM_DATA_W-1:0] pending;
    wire                    wr_enable;
    wire                    wr_status;

    // Place each event on the bit position that its enable occupies.
    assign evt_vec[31:26]                     = 6'h00;
    assign evt_vec[`EIEM_BIT_RX_DATA_OVR]     = evt_recv_data_overrun;
    assign evt_vec[`EIEM_BIT_RX_STAT_OVR]     = evt_recv_status_overrun;
    assign evt_vec[`EIEM_BIT_RX_BUF_CLOSED]   = evt_recv_buffer_closed;
    assign evt_vec[`EIEM_BIT_RX_DONE_A]       = evt_recv_finished_pool_a;
    assign evt_vec[`EIEM_BIT_RX_DONE_B]       = evt_recv_finished_pool_b;
    assign evt_vec[`EIEM_BIT_RX_DONE_C]       = evt_recv_finished_pool_c;
    assign evt_vec[`EIEM_BIT_RX_DONE_D]       = evt_recv_finished_pool_d;
    assign evt_vec[`EIEM_BIT_RX_NO_BUF]       = evt_recv_no_buffer;
    assign evt_vec[`EIEM_BIT_RX_BUF_FULL]     = evt_recv_buffer_full;
    assign evt_vec[`EIEM_BIT_RX_BCAST_REJ]    = evt_recv_broadcast_reject;
    assign evt_vec[15:7]                      = 9'h000;
    assign evt_vec[`EIEM_BIT_STAT_OVR]        = evt_statistics_overrun;
    assign evt_vec[`EIEM_BIT_SPARE]           = 1'b0;
    assign evt_vec[`EIEM_BIT_TX_BUF_CLOSED]   = evt_xmit_buffer_closed;
    assign evt_vec[`EIEM_BIT_TX_DESC_NRDY]    = evt_xmit_descriptor_not_ready;
    assign evt_vec[`EIEM_BIT_TX_DONE]         = evt_xmit_finished;
    assign evt_vec[1:0]                       = 2'h0;

    assign wr_enable = reg_wr && (reg_addr == `EIEM_OFS_ENABLE);
    assign wr_status = reg_wr && (reg_addr == `EIEM_OFS_STATUS);

    // Enable register: only source bits and the spare bit store a value.
    always @* begin
        nxt_enable = enable_ff;
        if (wr_enable) begin
            nxt_enable = reg_wdata & `EIEM_EN_WR_MASK;
        end
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            enable_ff <= `EIEM_ENABLE_RST;
        end else begin
            enable_ff <= nxt_enable;
        end
    end

    // Sticky status per bit; an event in the clearing cycle wins so none is lost.
    genvar gi;
    generate
        for (gi = 0; gi < `EIEM_DATA_W; gi = gi + 1) begin : g_status
            if (((`EIEM_SRC_MASK >> gi) & 1) != 0) begin : g_src
                assign nxt_status[gi] = evt_vec[gi] |
                                        (status_ff[gi] & ~(wr_status & reg_wdata[gi]));
            end else begin : g_none
                assign nxt_status[gi] = 1'b0;
            end
        end
    endgenerate

    always @(posedge mclk) begin
        if (sys_rst) begin
            status_ff <= `EIEM_STATUS_RST;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // The spare bit 5 never reaches the interrupt because it has no source.
    assign pending = status_ff & enable_ff & `EIEM_SRC_MASK;
    assign nxt_irq = |pending;

    // Registered so the line never glitches while status and enable change.
    always @(posedge mclk) begin
        if (sys_rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    assign sys_irq = irq_ff;

    // Read data appear the cycle after the strobe; unmapped addresses read zero.
    always @* begin
        nxt_rdata = `EIEM_RDATA_RST;
        if (reg_rd) begin
            case (reg_addr)
                `EIEM_OFS_ENABLE: begin
                    nxt_rdata = enable_ff;
                end
                `EIEM_OFS_STATUS: begin
                    nxt_rdata = status_ff;
                end
                `EIEM_OFS_RAW: begin
                    nxt_rdata = evt_vec;
                end
                `EIEM_OFS_PENDING: begin
                    nxt_rdata = pending;
                end
                default: begin
                    nxt_rdata = `EIEM_RDATA_RST;
                end
            endcase
        end
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            rdata_ff <= `EIEM_RDATA_RST;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // Each enable field is also visible to the neighbouring status logic.
    assign recv_data_overrun_irq_en         = enable_ff[`EIEM_BIT_RX_DATA_OVR];
    assign recv_status_overrun_irq_en       = enable_ff[`EIEM_BIT_RX_STAT_OVR];
    assign recv_buffer_closed_irq_en        = enable_ff[`EIEM_BIT_RX_BUF_CLOSED];
    assign recv_finished_pool_a_irq_en      = enable_ff[`EIEM_BIT_RX_DONE_A];
    assign recv_finished_pool_b_irq_en      = enable_ff[`EIEM_BIT_RX_DONE_B];
    assign recv_finished_pool_c_irq_en      = enable_ff[`EIEM_BIT_RX_DONE_C];
    assign recv_finished_pool_d_irq_en      = enable_ff[`EIEM_BIT_RX_DONE_D];
    assign recv_no_buffer_irq_en            = enable_ff[`EIEM_BIT_RX_NO_BUF];
    assign recv_buffer_full_irq_en          = enable_ff[`EIEM_BIT_RX_BUF_FULL];
    assign recv_broadcast_reject_irq_en     = enable_ff[`EIEM_BIT_RX_BCAST_REJ];
    assign statistics_overrun_irq_en        = enable_ff[`EIEM_BIT_STAT_OVR];
    assign xmit_buffer_closed_irq_en        = enable_ff[`EIEM_BIT_TX_BUF_CLOSED];
    assign xmit_descriptor_not_ready_irq_en = enable_ff[`EIEM_BIT_TX_DESC_NRDY];
    assign xmit_finished_irq_en             = enable_ff[`EIEM_BIT_TX_DONE];

endmodule // eiem_core

// File: tb/eiem_core_checker.sv
/*
 * Checker for the interrupt enable mask block: register read-back, masking and
 * interrupt timing, seen only through the block's ports.
 * Assumes the register map header is on the include path; bound to eiem_core.
 */
`timescale 1ns/10ps
`include "eiem_map.vh"
module eiem_checker (
    input wire                     mclk,
    input wire                     sys_rst,
    input wire                     reg_wr,
    input wire                     reg_rd,
    input wire                     sys_irq,
    input wire [`EIEM_ADDR_W-1:0]  reg_addr,
    input wire [`EIEM_DATA_W-1:0]  reg_wdata,
    input wire [`EIEM_DATA_W-1:0]  reg_rdata
);
    // Shadow of the enable register, so read-back can be judged without events.
    reg [31:0] shadow_ff;
    always @(posedge mclk) begin
        if (sys_rst)
            shadow_ff <= 32'h00000000;
        else if (reg_wr && reg_addr == `EIEM_OFS_ENABLE)
            shadow_ff <= reg_wdata & `EIEM_EN_WR_MASK;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_en_rd; reg_rd && reg_addr == `EIEM_OFS_ENABLE; endsequence
    sequence s_pend_rd; reg_rd && reg_addr == `EIEM_OFS_PENDING; endsequence
    sequence s_bad_rd; reg_rd && reg_addr[1:0] != 2'h0 || reg_rd && reg_addr > 8'h0C; endsequence
    sequence s_en_clr; reg_wr && reg_addr == `EIEM_OFS_ENABLE && (reg_wdata & `EIEM_SRC_MASK) == 0;
    endsequence
    property p_en_rd; s_en_rd |=> reg_rdata == shadow_ff; endproperty
    property p_pend_irq; s_pend_rd |=> (reg_rdata != 32'h0) == sys_irq; endproperty
    property p_pend_sub; s_pend_rd |=> (reg_rdata & ~shadow_ff) == 32'h0; endproperty
    property p_mask; sys_irq |-> ($past(shadow_ff) & `EIEM_SRC_MASK) != 32'h0; endproperty
    property p_resv; reg_rd |=> (reg_rdata & ~`EIEM_EN_WR_MASK) == 32'h0; endproperty
    property p_unmapped; s_bad_rd |=> reg_rdata == 32'h0; endproperty
    property p_rst; $fell(sys_rst) |-> reg_rdata == 32'h0 && !sys_irq; endproperty
    property p_en_off; s_en_clr |=> ##1 !sys_irq; endproperty
    a_en_rd: assert property (p_en_rd)
        else $error("enable read-back differs from written value");
    a_pend_irq: assert property (p_pend_irq)
        else $error("interrupt line disagrees with pending flags");
    a_pend_sub: assert property (p_pend_sub)
        else $error("pending flag shown for a disabled source");
    a_mask: assert property (p_mask)
        else $error("interrupt high with all sources disabled");
    a_resv: assert property (p_resv)
        else $error("reserved bits read nonzero");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned data");
    a_rst: assert property (p_rst)
        else $error("outputs not cleared by reset");
    a_en_off: assert property (p_en_off)
        else $error("interrupt survived clearing all enables");
endmodule // eiem_checker
bind eiem_core eiem_checker i_chk (.mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .sys_irq(sys_irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));

// File: tb/tb_eiem_core.sv
/*
 * Self-checking testbench for the interrupt enable mask block: corner walks per
 * bit, then seeded random register and event traffic against a bench model.
 * Assumes the register map header is on the include path.
 */
`timescale 1ns/10ps
`include "eiem_map.vh"
module tb_eiem_core;
    logic        mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, x_irq = 0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, evt = 32'h0, st = 32'h0, en_m = 32'h0, x_rd = 32'h0, b, op;
    wire  [31:0] reg_rdata, en;
    wire         sys_irq;
    // Positions with no enable output are tied low so the whole word is driven.
    assign {en[31:26], en[15:7], en[5], en[1:0]} = 18'h00000;
    integer      n_errors = 0, samples_checked = 0, seed = 78973, cyc_n = 0, i;
    always #10 mclk = ~mclk;
    eiem_core i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_irq(sys_irq),
        .evt_recv_data_overrun(evt[25]), .evt_recv_status_overrun(evt[24]),
        .evt_recv_buffer_closed(evt[23]), .evt_recv_finished_pool_a(evt[22]),
        .evt_recv_finished_pool_b(evt[21]), .evt_recv_finished_pool_c(evt[20]),
        .evt_recv_finished_pool_d(evt[19]), .evt_recv_no_buffer(evt[18]),
        .evt_recv_buffer_full(evt[17]), .evt_recv_broadcast_reject(evt[16]),
        .evt_statistics_overrun(evt[6]), .evt_xmit_buffer_closed(evt[4]),
        .evt_xmit_descriptor_not_ready(evt[3]), .evt_xmit_finished(evt[2]),
        .recv_data_overrun_irq_en(en[25]), .recv_status_overrun_irq_en(en[24]),
        .recv_buffer_closed_irq_en(en[23]), .recv_finished_pool_a_irq_en(en[22]),
        .recv_finished_pool_b_irq_en(en[21]), .recv_finished_pool_c_irq_en(en[20]),
        .recv_finished_pool_d_irq_en(en[19]), .recv_no_buffer_irq_en(en[18]),
        .recv_buffer_full_irq_en(en[17]), .recv_broadcast_reject_irq_en(en[16]),
        .statistics_overrun_irq_en(en[6]), .xmit_buffer_closed_irq_en(en[4]),
        .xmit_descriptor_not_ready_irq_en(en[3]), .xmit_finished_irq_en(en[2]));
    task final_report;
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function logic [31:0] val(input logic [7:0] a, input logic [31:0] e);
        case (a)
            `EIEM_OFS_ENABLE: val = en_m;
            `EIEM_OFS_STATUS: val = st;
            `EIEM_OFS_RAW: val = e;
            `EIEM_OFS_PENDING: val = st & en_m & `EIEM_SRC_MASK;
            default: val = 32'h00000000;
        endcase
    endfunction
    // One bus cycle; outputs are checked at the falling edge, clear of the launching edge.
    task cyc(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d, e);
        if (w && a == `EIEM_OFS_ENABLE)
            d = d & ~(32'h1 << `EIEM_BIT_SPARE);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        evt <= e & `EIEM_SRC_MASK;
        @(negedge mclk);
        chk(reg_rdata, x_rd);
        chk({31'h0, sys_irq}, {31'h0, x_irq});
        chk(en & `EIEM_SRC_MASK, en_m & `EIEM_SRC_MASK);
        @(posedge mclk);
        x_rd = r ? val(a, e & `EIEM_SRC_MASK) : 32'h0;
        x_irq = |(st & en_m & `EIEM_SRC_MASK);
        if (w && a == `EIEM_OFS_ENABLE)
            en_m = d & `EIEM_EN_WR_MASK;
        st = ((w && a == `EIEM_OFS_STATUS) ? st & ~d : st) | (e & `EIEM_SRC_MASK);
    endtask
    always @(posedge mclk) begin
        cyc_n = cyc_n + 1;
        if (cyc_n == 4000) begin
            n_errors = n_errors + 1;
            final_report;
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 0;
        cyc(0, 0, 8'h00, 32'h0, 32'h0);
        cyc(0, 1, 8'h10, 32'h0, 32'h0);
        cyc(0, 1, 8'hFF, 32'h0, 32'h0);
        cyc(1, 0, `EIEM_OFS_ENABLE, 32'hFFFFFFFF, 32'h0);
        cyc(0, 1, `EIEM_OFS_ENABLE, 32'h0, 32'h0);
        for (i = 0; i < 32; i = i + 1) begin
            b = 32'h1 << i;
            cyc(1, 0, `EIEM_OFS_ENABLE, ~b, b);
            cyc(0, 1, `EIEM_OFS_STATUS, 32'h0, 32'h0);
            cyc(1, 0, `EIEM_OFS_ENABLE, b, 32'h0);
            cyc(0, 1, `EIEM_OFS_PENDING, 32'h0, 32'h0);
            cyc(1, 0, `EIEM_OFS_STATUS, b, b);
            cyc(1, 0, `EIEM_OFS_STATUS, b, 32'h0);
            cyc(1, 0, `EIEM_OFS_ENABLE, 32'h0, 32'h0);
            cyc(0, 1, `EIEM_OFS_ENABLE, 32'h0, 32'h0);
        end
        for (i = 0; i < 1500; i = i + 1) begin
            op = $random(seed);
            b = $random(seed);
            cyc(op[1:0] == 2'h1, op[1:0] == 2'h2, op[9] ? op[17:10] : {4'h0, op[5:4], 2'h0},
                b, $random(seed) & $random(seed) & $random(seed));
        end
        cyc(0, 0, 8'h00, 32'h0, 32'h0);
        final_report;
    end
endmodule // tb_eiem_core
